/* File: design/wcs_top.sv */
// Word clock source selection, monitoring and output regeneration with Avalon-MM registers
//
// The Avalon-MM slave port and the register addresses are this design's own decisions.
`include "wcs_regs.svh"
//Function
//- External word clock used only when selected and a valid signal is present.
//- Single, double and quad speed inputs accepted, speed class adapted automatically.
//- Valid input lights presence indicator and reports lock or sync status.
//- Word clock output runs at current rate in every mode, except while a selected input is silent and loss is not yet detected.
//- Master mode output runs at the host requested sample rate.
//- Slave mode output frequency equals the selected input frequency.
//- On reference loss, switch to master at nearest standard rate.
//- Single speed option keeps output within 32 to 48 kHz.
//- User setting connects or removes internal 75 ohm input termination.
//- Regenerated output phase locked and in phase with the input.
//- Reported current source becomes word clock only once input is valid.
module wcs_top
  import wcs_pkg::*;
#(
  parameter int LOSS_CYCLES = `WCS_LOSS_TIME_NS / `WCS_CLK_PERIOD_NS
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [4:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  input  wire logic        wc_in,
  output logic             wc_out,
  output logic             wc_term_en_out,
  output logic             reference_present_led_out,
  output logic             irq_out
);
  wcs_ctrl_t   ctrl;
  wcs_meas_t   meas;
  logic        meas_valid_q;
  wcs_rate_t   meas_rate_q;
  logic        in_use;
  logic        fallback;
  wcs_rate_t   fb_rate;
  logic [2:0]  irq_stat;
  logic [2:0]  irq_en;
  logic [2:0]  next_events;
  wcs_rate_t   master_rate;
  wcs_rate_t   eff_rate;
  wcs_rate_t   gen_rate;
  logic [1:0]  gen_div;
  logic        req;
  logic        bus_ack;
  logic        wr_ctrl;
  logic        wr_clr;
  logic        wr_en;
  logic [31:0] status_word;
  logic        seen_lock;
  wcs_rate_t   lock_rate;
  logic        wc_out_q;

  // Input measurement and validity; the meter holds the edge detector used for validity and rate,
  // so every consumer of those sees the same decision; wcs_clock_gen samples the pin on its own
  wcs_period_meter #(
    .LOSS_CYCLES (LOSS_CYCLES)
  ) u_meter (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .wc_in    (wc_in),
    .meas_out (meas)
  );

  // Bus handshake: one wait cycle, then the request is taken
  // Fixed latency keeps read data and write strobes simple; the cost is three
  // clocks per access for a master that idles one cycle between requests
  assign req     = avs_read_in | avs_write_in;
  assign bus_ack = req & ~avs_waitrequest_out;
  assign wr_ctrl = bus_ack & avs_write_in & avs_byteenable_in[0] &
                   (avs_address_in == `WCS_OFF_CTRL);
  assign wr_clr  = bus_ack & avs_write_in & avs_byteenable_in[0] &
                   (avs_address_in == `WCS_OFF_IRQ_CLR);
  assign wr_en   = bus_ack & avs_write_in & avs_byteenable_in[0] &
                   (avs_address_in == `WCS_OFF_IRQ_EN);

  // Waitrequest is a flop, low for exactly one cycle per request
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      avs_waitrequest_out <= 1'b1;
    else
      avs_waitrequest_out <= ~(req & avs_waitrequest_out);
  end

  // Status word: validity, lock/sync, speed class, source in use, rates
  // Lock and sync exclude each other: sync only while the input really clocks us,
  // so software never mistakes a merely present signal for the reference
  always_comb begin
    status_word     = 32'h0;
    status_word[0]  = meas_valid_q;
    status_word[1]  = meas_valid_q & ~in_use;    // Lock only, not reference
    status_word[2]  = in_use;                    // Sync: input drives clock
    status_word[3]  = in_use;                    // Current source is word clock
    status_word[4]  = fallback;
    status_word[6:5] = wcs_speed(meas_rate_q);
    status_word[10:8] = meas_rate_q;
    status_word[14:12] = eff_rate;
  end

  // Read data are latched in the wait cycle so they stand at the accepting edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      avs_readdata_out <= 32'h0;
    end else if (avs_read_in && avs_waitrequest_out) begin
      unique case (avs_address_in)
        `WCS_OFF_CTRL:     avs_readdata_out <= {25'h0, ctrl.rate, 1'b0, ctrl.term,
                                                ctrl.single, ctrl.sel_word};
        `WCS_OFF_STATUS:   avs_readdata_out <= status_word;
        `WCS_OFF_IRQ_STAT: avs_readdata_out <= {29'h0, irq_stat};
        `WCS_OFF_IRQ_EN:   avs_readdata_out <= {29'h0, irq_en};
        default:           avs_readdata_out <= 32'h0; // Clear register and holes read zero
      endcase
    end
  end

  // User settings: source select, single speed clamp, termination, host rate
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Host rate comes up at 48 kHz, source internal, no termination
      ctrl.rate     <= 3'(`WCS_CTRL_RESET >> `WCS_CTRL_RATE_LSB);
      ctrl.term     <= 1'b0;
      ctrl.single   <= 1'b0;
      ctrl.sel_word <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl.sel_word <= avs_writedata_in[`WCS_CTRL_SEL_BIT];
      ctrl.single   <= avs_writedata_in[`WCS_CTRL_SINGLE_BIT];
      ctrl.term     <= avs_writedata_in[`WCS_CTRL_TERM_BIT];
      ctrl.rate     <= avs_writedata_in[`WCS_CTRL_RATE_LSB +: 3];
    end
  end

  // Termination relay follows the setting; open when cleared
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      wc_term_en_out <= 1'b0;
    else
      wc_term_en_out <= ctrl.term;
  end

  // Measurement snapshot and presence indicator
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meas_valid_q              <= 1'b0;
      meas_rate_q               <= 3'h0;
      reference_present_led_out <= 1'b0;
    end else begin
      meas_valid_q              <= meas.valid;
      meas_rate_q               <= meas.rate;
      reference_present_led_out <= meas.valid;
    end
  end

  // Reference in use only when selected and valid, so the report is honest
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      in_use <= 1'b0;
    else
      in_use <= ctrl.sel_word & meas.valid;
  end

  // Loss while in use falls back to master at the last measured standard rate;
  // a new control write hands the rate back to the host
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      fallback <= 1'b0;
      fb_rate  <= 3'h0;
    end else begin
      if (in_use)
        fb_rate <= meas.rate;
      if (in_use && !meas.valid)
        fallback <= 1'b1;
      else if (wr_ctrl || in_use)
        fallback <= 1'b0;
    end
  end

  // Rate selection for the output generator
  always_comb begin
    master_rate = fallback ? fb_rate : ctrl.rate;
    eff_rate    = in_use ? meas_rate_q : master_rate;
    gen_rate    = ctrl.single ? wcs_single(master_rate) : master_rate;
    gen_div     = ctrl.single ? wcs_speed(meas_rate_q) : 2'h0;
  end

  // Output word clock; it keeps running while the source is switched, but while a selected
  // input is silent it copies the still line until the meter declares loss and fallback takes over
  wcs_clock_gen u_gen (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .slave_in (in_use),
    .rate_in  (gen_rate),
    .div_in   (gen_div),
    .wc_in    (wc_in),
    .wc_out   (wc_out)
  );

  // Events: lock gained, reference lost, relock at a rate other than the last locked one
  always_comb begin
    next_events                   = 3'h0;
    next_events[`WCS_IRQ_LOCK_BIT] = meas.valid & ~meas_valid_q;
    next_events[`WCS_IRQ_LOSS_BIT] = ~meas.valid & meas_valid_q;
    next_events[`WCS_IRQ_RATE_BIT] = meas.valid & seen_lock & (meas.rate != lock_rate);
  end

  // Last locked rate: the meter drops validity before it accepts a new rate,
  // so a rate change shows up as a relock at another rate
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      seen_lock <= 1'b0;
      lock_rate <= 3'h0;
    end else if (meas.valid) begin
      seen_lock <= 1'b1;
      lock_rate <= meas.rate;
    end
  end

  // Sticky status: a set in the same cycle as its clear wins
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_stat <= `WCS_IRQ_RESET;
      irq_en   <= `WCS_IRQ_RESET;
    end else begin
      irq_stat <= (irq_stat & ~(wr_clr ? avs_writedata_in[2:0] : 3'h0)) | next_events;
      if (wr_en)
        irq_en <= avs_writedata_in[2:0];
    end
  end

  // Level interrupt from a flop
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      irq_out <= 1'b0;
    else
      irq_out <= |(irq_stat & irq_en);
  end

  // Helper: cycles since the output last changed
  logic [15:0] quiet_cnt;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wc_out_q  <= 1'b0;
      quiet_cnt <= 16'h0;
    end else begin
      wc_out_q <= wc_out;
      if (wc_out != wc_out_q)
        quiet_cnt <= 16'h0;
      else if (quiet_cnt != 16'hffff)
        quiet_cnt <= quiet_cnt + 16'h1;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  use_ext_a: assert property (
    in_use |-> $past(ctrl.sel_word) && $past(meas.valid))
    else $error("external reference used without selection and validity");
  speed_follow_a: assert property (
    in_use && $stable(meas_rate_q) |-> eff_rate == meas_rate_q)
    else $error("effective rate does not follow the detected input rate");
  led_valid_a: assert property (
    $rose(meas.valid) |=> reference_present_led_out ##1 status_word[0])
    else $error("presence indicator or status late after valid input");
  out_active_a: assert property (
    !in_use && !fallback && $stable(ctrl) |-> quiet_cnt < 16'd1000)
    else $error("output word clock stalled in master mode");
  master_rate_a: assert property (
    !in_use && !fallback && !ctrl.single |-> gen_rate == ctrl.rate)
    else $error("master output not at host rate");
  slave_phase_a: assert property (
    in_use && gen_div == 2'h0 && $rose(wc_in) ##1 in_use |-> ##[0:1] wc_out)
    else $error("regenerated output lags input edge");
  loss_fallback_a: assert property (
    in_use && !meas.valid |=> fallback && !in_use && fb_rate == $past(fb_rate))
    else $error("no fallback to master on reference loss");
  single_clamp_a: assert property (
    ctrl.single |-> wcs_speed(gen_rate) == 2'h0)
    else $error("single speed output above 48 kHz");
  term_follow_a: assert property (
    $changed(ctrl.term) |=> wc_term_en_out == $past(ctrl.term))
    else $error("termination does not follow setting");
  src_report_a: assert property (
    !meas.valid |=> !status_word[3])
    else $error("word clock reported as source without valid input");
  deselect_a: assert property (
    !ctrl.sel_word |=> !in_use)
    else $error("word clock used after it was deselected");
  led_drop_a: assert property (
    $fell(meas.valid) |=> !reference_present_led_out)
    else $error("presence indicator stays lit after loss");
  fallback_hold_a: assert property (
    fallback && !wr_ctrl && !in_use |=> fallback)
    else $error("fallback left without host write or usable input");

  // Bus handshake guards
  wait_single_a: assert property (
    req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("request not answered after one wait cycle");
  wait_short_a: assert property (
    !avs_waitrequest_out |=> avs_waitrequest_out)
    else $error("waitrequest low for more than one cycle");
  ctrl_write_a: assert property (
    wr_ctrl |=> ctrl.rate == $past(avs_writedata_in[`WCS_CTRL_RATE_LSB +: 3]) &&
                ctrl.sel_word == $past(avs_writedata_in[`WCS_CTRL_SEL_BIT]))
    else $error("control write did not land");
  be_guard_a: assert property (
    avs_write_in && !avs_byteenable_in[0] |=> $stable(ctrl) && $stable(irq_en))
    else $error("write without low byte enable changed a register");

  // Event and interrupt guards
  en_write_a: assert property (
    wr_en |=> irq_en == $past(avs_writedata_in[2:0]))
    else $error("interrupt enable write did not land");
  clr_write_a: assert property (
    wr_clr && next_events == 3'h0 |=> (irq_stat & $past(avs_writedata_in[2:0])) == 3'h0)
    else $error("status clear did not clear");
  lock_event_a: assert property (
    $rose(meas.valid) |=> irq_stat[`WCS_IRQ_LOCK_BIT])
    else $error("lock event lost");
  loss_event_a: assert property (
    $fell(meas.valid) |=> irq_stat[`WCS_IRQ_LOSS_BIT])
    else $error("loss event lost");
  rate_event_a: assert property (
    $rose(meas.valid) && seen_lock && meas.rate != lock_rate |=> irq_stat[`WCS_IRQ_RATE_BIT])
    else $error("relock at a new rate not flagged");
  irq_level_a: assert property (
    |(irq_stat & irq_en) |=> irq_out)
    else $error("interrupt low while an enabled status bit is set");

  lock_seen_c:    cover property ($rose(in_use));
  fallback_c:     cover property ($rose(fallback));
  single_slave_c: cover property (in_use && gen_div == 2'h2);
  irq_c:          cover property ($rose(irq_out));
  rate_event_c:   cover property (next_events[`WCS_IRQ_RATE_BIT]);
endmodule

/* File: design/wcs_regs.svh */
// Register offsets, field positions, reset values and timing counts of the word clock selector
`ifndef WCS_REGS_SVH
`define WCS_REGS_SVH
`define WCS_CLK_HZ          50000000
`define WCS_CLK_PERIOD_NS   20
`define WCS_LOSS_TIME_NS    100000
`define WCS_VALID_PERIODS   4
`define WCS_TOL_SHIFT       6
`define WCS_OFF_CTRL        5'h00
`define WCS_OFF_STATUS      5'h04
`define WCS_OFF_IRQ_STAT    5'h08
`define WCS_OFF_IRQ_CLR     5'h0c
`define WCS_OFF_IRQ_EN      5'h10
`define WCS_CTRL_SEL_BIT    0
`define WCS_CTRL_SINGLE_BIT 1
`define WCS_CTRL_TERM_BIT   2
`define WCS_CTRL_RATE_LSB   4
`define WCS_CTRL_RESET      8'h20
`define WCS_IRQ_LOCK_BIT    0
`define WCS_IRQ_LOSS_BIT    1
`define WCS_IRQ_RATE_BIT    2
`define WCS_IRQ_RESET       3'h0
`endif

/* File: design/wcs_pkg.sv */
// Types and rate helpers shared by the word clock selector modules
`include "wcs_regs.svh"
package wcs_pkg;
  // Rate codes: 0..2 single, 3..5 double, 6..7 quad speed
  typedef logic [2:0] wcs_rate_t;
  typedef struct packed {
    wcs_rate_t rate;
    logic      term;
    logic      single;
    logic      sel_word;
  } wcs_ctrl_t;
  typedef struct packed {
    logic      valid;
    wcs_rate_t rate;
  } wcs_meas_t;

  function automatic logic [31:0] wcs_rate_hz(input wcs_rate_t r);
    unique case (r)
      3'h0: wcs_rate_hz = 32'd32000;
      3'h1: wcs_rate_hz = 32'd44100;
      3'h2: wcs_rate_hz = 32'd48000;
      3'h3: wcs_rate_hz = 32'd64000;
      3'h4: wcs_rate_hz = 32'd88200;
      3'h5: wcs_rate_hz = 32'd96000;
      3'h6: wcs_rate_hz = 32'd176400;
      3'h7: wcs_rate_hz = 32'd192000;
    endcase
  endfunction

  // Speed class: 0 single, 1 double, 2 quad
  function automatic logic [1:0] wcs_speed(input wcs_rate_t r);
    wcs_speed = (r > 3'h5) ? 2'h2 : ((r > 3'h2) ? 2'h1 : 2'h0);
  endfunction

  // Folds a double or quad rate down to its single speed base
  function automatic wcs_rate_t wcs_single(input wcs_rate_t r);
    unique case (r)
      3'h3:    wcs_single = 3'h0;
      3'h4:    wcs_single = 3'h1;
      3'h5:    wcs_single = 3'h2;
      3'h6:    wcs_single = 3'h1;
      3'h7:    wcs_single = 3'h2;
      default: wcs_single = r;
    endcase
  endfunction
endpackage

/* File: design/wcs_period_meter.sv */
// Word clock input period measurement, rate classification and validity
`include "wcs_regs.svh"
module wcs_period_meter
  import wcs_pkg::*;
#(
  parameter int LOSS_CYCLES = `WCS_LOSS_TIME_NS / `WCS_CLK_PERIOD_NS
) (
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      wc_in,
  output wcs_meas_t      meas_out
);
  logic        wc_q;
  logic [15:0] period;
  logic [2:0]  good;
  logic        hit;
  wcs_rate_t   code;

  // Finds the rate whose nominal period lies within 1/64 of the count
  always_comb begin
    logic [31:0] nom;
    nom  = 32'h0;
    hit  = 1'b0;
    code = 3'h0;
    for (int i = 0; i < 8; i++) begin
      nom = 32'(`WCS_CLK_HZ) / wcs_rate_hz(3'(i));
      if ({16'h0, period} + (nom >> `WCS_TOL_SHIFT) >= nom &&
          {16'h0, period} <= nom + (nom >> `WCS_TOL_SHIFT)) begin
        hit  = 1'b1;
        code = 3'(i);
      end
    end
  end

  // Valid after several matching periods; lost on mismatch or silence
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wc_q     <= 1'b0;
      period   <= 16'h0;
      good     <= 3'h0;
      meas_out <= '0;
    end else begin
      wc_q <= wc_in;
      if (wc_in && !wc_q) begin
        period <= 16'h1;
        if (hit && (good == 3'h0 || code == meas_out.rate)) begin
          meas_out.rate <= code;
          if (good != 3'(`WCS_VALID_PERIODS))
            good <= good + 3'h1;
          else
            meas_out.valid <= 1'b1;
        end else begin
          good           <= 3'h0;
          meas_out.valid <= 1'b0;
        end
      end else if (32'(period) >= LOSS_CYCLES) begin
        good           <= 3'h0;
        meas_out.valid <= 1'b0;
      end else begin
        period <= period + 16'h1;
      end
    end
  end

  valid_after_run_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(meas_out.valid) |-> good == 3'(`WCS_VALID_PERIODS))
    else $error("input declared valid before enough matching periods");
endmodule

/* File: design/wcs_clock_gen.sv */
// Word clock output: phase accumulator in master mode, edge-aligned divider in slave mode
`include "wcs_regs.svh"
module wcs_clock_gen
  import wcs_pkg::*;
(
  input  wire logic      clk_in,
  input  wire logic      rst_n_in,
  input  wire logic      slave_in,
  input  wcs_rate_t      rate_in,
  input  wire logic [1:0] div_in,
  input  wire logic      wc_in,
  output logic           wc_out
);
  logic [31:0] acc;
  logic        wc_q;
  logic        skip;

  // Increment gives rate * 2^32 / clock per cycle; fractional rates need no PLL
  function automatic logic [31:0] wcs_inc(input wcs_rate_t r);
    wcs_inc = 32'(({32'h0, wcs_rate_hz(r)} << 32) / 64'(`WCS_CLK_HZ));
  endfunction

  // Master accumulates; slave copies or divides input so rising edges coincide
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc    <= 32'h0;
      wc_q   <= 1'b0;
      skip   <= 1'b0;
      wc_out <= 1'b0;
    end else begin
      wc_q <= wc_in;
      if (!slave_in) begin
        acc    <= acc + wcs_inc(rate_in);
        wc_out <= acc[31];
      end else if (div_in == 2'h0) begin
        wc_out <= wc_q;
      end else if (wc_q && !wc_out && wc_in) begin
        wc_out <= 1'b0;
      end else if (wc_in && !wc_q) begin
        skip <= ~skip;
        if (div_in == 2'h1 || skip)
          wc_out <= ~wc_out;
      end
    end
  end
endmodule

/* File: verification/wcs_wc_source.sv */
// Behavioural external word clock source driving the selector input
module wcs_wc_source (
  input  wire logic        clk_in,
  input  wire logic        run_in,
  input  wire logic [31:0] period_in,
  output logic             wc_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;

  // Square wave of period_in clock cycles, frozen low while stopped
  // Stopping holds the line: a real dead source makes no edges at all
  initial begin
    wc_out = 1'b0;
    cnt = 0;
  end
  always @(posedge clk_in) begin
    if (!run_in) begin
      cnt <= 0;
      wc_out <= 1'b0;
    end else begin
      cnt <= (cnt + 1 >= period_in) ? 0 : cnt + 1;
      wc_out <= (cnt < period_in / 2);
    end
  end
endmodule

/* File: verification/wcs_top_tb.sv */
// Register-level bench of the word clock selector with an external source
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module wcs_top_tb;
  import wcs_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int LOSS = 2000;
  logic        clk_in;
  logic        rst_n_in;
  logic [4:0]  adr;
  logic        rd;
  logic        wr;
  logic [31:0] wdat;
  logic [3:0]  be;
  logic [31:0] rdat;
  logic        wreq;
  logic        wc_in;
  logic        wc_out;
  logic        term;
  logic        led;
  logic        irq;
  logic        run;
  int          per;
  int          err_count;
  int          n_tests;
  logic [31:0] v;
  int          n;
  logic [1:0]  hist;

  wcs_top #(.LOSS_CYCLES(LOSS)) wcs_top_i (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_byteenable_in(be),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wreq), .wc_in(wc_in),
    .wc_out(wc_out), .wc_term_en_out(term), .reference_present_led_out(led),
    .irq_out(irq));
  wcs_wc_source wcs_wc_source_i (.clk_in(clk_in), .run_in(run), .period_in(per),
    .wc_out(wc_in));

  // 50 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Bus request held until the edge that sees waitrequest low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b, output logic [31:0] q);
    int k;
    @(posedge clk_in);
    adr <= a;
    wdat <= d;
    be <= b;
    rd <= !w;
    wr <= w;
    for (k = 0; k < 50; k++) begin
      @(posedge clk_in);
      if (wreq === 1'b0) break;
    end
    q = rdat;
    if (k == 50) `CHK("waitrequest", 1'b0, 1'b1)
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task automatic rreg(input logic [4:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0, 4'hf, q);
  endtask

  task automatic cyc(input int c);
    repeat (c) @(posedge clk_in);
  endtask

  // Cycles between two rising edges of the output clock, sampled at edges
  task automatic period_of(output int c);
    logic p;
    int k;
    c = 0;
    for (k = 0; k < 2; k++) begin
      p = wc_out;
      @(posedge clk_in);
      while (!(wc_out === 1'b1 && p === 1'b0) && c < 9000) begin
        p = wc_out;
        @(posedge clk_in);
        if (k == 1) c++;
      end
    end
    c++;
  endtask

  task automatic complete_run;
    $display("Tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog at 60k cycles, well beyond the roughly 25k cycles the tests need
  initial begin
    #1200000;
    err_count++;
    complete_run();
  end

  initial begin
    {adr, rd, wr, wdat, be, run, err_count, n_tests} = '0;
    per = 260;
    rst_n_in = 1'b0;
    cyc(6);
    rst_n_in <= 1'b1;
    // Reset values, unmapped place and refused writes
    rreg(5'h00, v); `CHK("ctrl reset", 32'h20, v)
    rreg(5'h08, v); `CHK("irq stat reset", 32'h0, v)
    rreg(5'h10, v); `CHK("irq en reset", 32'h0, v)
    rreg(5'h14, v); `CHK("unmapped", 32'h0, v)
    wreg(5'h14, 32'hff);
    bus(1'b1, 5'h00, 32'h24, 4'he, v);
    rreg(5'h00, v); `CHK("ctrl kept", 32'h20, v)
    `CHK("term off", 1'b0, term)
    wreg(5'h00, 32'h24);
    cyc(2); `CHK("term on", 1'b1, term)
    $display("Test registers done");
    // Master output at host rate 96 kHz, about 520.8 cycles
    wreg(5'h00, 32'h50);
    period_of(n); `CHK("master 96k", 1'b1, n >= 520 && n <= 522)
    `CHK("term off", 1'b0, term)
    $display("Test master done");
    // Word clock selected but absent: not used, no indicator
    wreg(5'h00, 32'h71);
    cyc(600);
    rreg(5'h04, v); `CHK("src before valid", 1'b0, v[3])
    `CHK("led off", 1'b0, led)
    run <= 1'b1;
    cyc(3000);
    rreg(5'h04, v);
    `CHK("valid sync src", 4'hd, v[3:0])
    `CHK("quad class", 2'h2, v[6:5])
    `CHK("measured 192k", 3'h7, v[10:8])
    `CHK("led on", 1'b1, led)
    rreg(5'h08, v); `CHK("lock event", 1'b1, v[0])
    wreg(5'h10, 32'h1);
    cyc(3); `CHK("irq high", 1'b1, irq)
    wreg(5'h0c, 32'h1);
    cyc(3); `CHK("irq cleared", 1'b0, irq)
    rreg(5'h08, v); `CHK("lock event clr", 1'b0, v[0])
    // Slave output follows input two cycles later, in phase
    // Prime the history with the two inputs the output still echoes
    hist = 2'b00;
    repeat (2) begin
      @(posedge clk_in);
      hist = {hist[0], wc_in};
    end
    n = 0;
    repeat (600) begin
      @(posedge clk_in);
      if (wc_out !== hist[1]) n++;
      hist = {hist[0], wc_in};
    end
    `CHK("slave in phase", 0, n)
    // Single speed folds quad input by four
    wreg(5'h00, 32'h73);
    cyc(1100); // Let the copy-mode edges pass before timing the divider
    period_of(n); `CHK("single 48k", 1040, n)
    $display("Test slave done");
    // Valid input not selected reports lock only
    wreg(5'h00, 32'h70);
    cyc(10);
    rreg(5'h04, v); `CHK("lock only", 4'h3, v[3:0])
    // Speed change to a single speed input
    per <= 1042;
    wreg(5'h00, 32'h71);
    cyc(9000);
    rreg(5'h04, v);
    `CHK("single class", 2'h0, v[6:5])
    `CHK("measured 48k", 3'h2, v[10:8])
    rreg(5'h08, v); `CHK("rate event", 1'b1, v[2])
    $display("Test speed done");
    // Loss falls back to master at the last matching rate
    wreg(5'h10, 32'h0);
    wreg(5'h0c, 32'h7);
    run <= 1'b0;
    cyc(LOSS + 1200);
    rreg(5'h04, v);
    `CHK("invalid", 1'b0, v[0])
    `CHK("fallback", 1'b1, v[4])
    `CHK("fallback rate", 3'h2, v[14:12])
    `CHK("led off", 1'b0, led)
    rreg(5'h08, v); `CHK("loss event", 1'b1, v[1])
    `CHK("irq masked", 1'b0, irq)
    period_of(n); `CHK("fallback 48k", 1'b1, n >= 1041 && n <= 1043)
    $display("Test loss done");
    complete_run();
  end
endmodule
